/* File: src/sbg_pkg.sv */
package sbg_pkg;
  // apb byte addresses (word aligned)
  localparam logic [11:0] ADDR_DIV_LOW   = 12'h000;
  localparam logic [11:0] ADDR_DIV_HIGH  = 12'h004;
  localparam logic [11:0] ADDR_RATE_CTL  = 12'h008;
  localparam logic [11:0] ADDR_TX_CTL    = 12'h00C;
  localparam logic [11:0] ADDR_RX_CTL    = 12'h010;
  // field positions
  localparam int RX_IDLE_BIT   = 6;
  localparam int WIDE_DIV_BIT  = 3;
  localparam int SYNC_BIT      = 4;
  localparam int HIGH_SPD_BIT  = 2;
  // reset values and write masks
  localparam logic [7:0] RST_DIV      = 8'h00;
  localparam logic [7:0] RST_CTL      = 8'h00;
  localparam logic [7:0] RATE_CTL_MASK = 8'h18;
  localparam logic [7:0] TX_CTL_MASK   = 8'hFC;
  localparam logic [7:0] RX_CTL_MASK   = 8'hF8;
  // prescale: cycles per divider step, minus one
  localparam logic [5:0] PRE_64 = 6'h3F;
  localparam logic [5:0] PRE_16 = 6'h0F;
  localparam logic [5:0] PRE_4  = 6'h03;
  localparam logic [5:0] PRE_0  = 6'h00;
  localparam logic [15:0] CNT_0 = 16'h0000;

  typedef struct packed {
    logic       sync_mode;
    logic       wide_divider_sel;
    logic       high_speed_sel;
    logic [15:0] divisor;
  } sbg_cfg_t;
endpackage : sbg_pkg

/* File: src/sbg_top.sv */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1: free-running timer, 8-bit default, 16-bit when wide
// R2: divisor high gives 15:8, low gives 7:0
// R3: async divide 64(n+1), or 16(n+1) wide
// R4: sync ignores high-speed, divides 4(n+1)
// R5: divisor write clears the running timer
// R6: software checks rx idle before clock change
// R7: one timer serves async and sync
// R8: async high-speed: 16(n+1) narrow, 4(n+1) wide
module sbg_top (
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        rx_idle_flag_i,
  output logic             rate_tick_o
);
  ////////////////////////////////////////////////////////////////////////
  logic [7:0]  div_low_reg, div_high_reg, rate_ctl_reg, tx_ctl_reg, rx_ctl_reg;
  logic [5:0]  pre_reg, pre_next;
  logic [15:0] cnt_reg, cnt_next;
  logic        tick_reg;
  logic        rx_idle_s1_reg, rx_idle_s2_reg, rx_idle_s3_reg, rx_idle_reg;
  sbg_pkg::sbg_cfg_t cfg;

  wire wr_en   = psel_i && penable_i && pwrite_i;
  wire hit_lo  = paddr_i == sbg_pkg::ADDR_DIV_LOW;
  wire hit_hi  = paddr_i == sbg_pkg::ADDR_DIV_HIGH;
  wire hit_rc  = paddr_i == sbg_pkg::ADDR_RATE_CTL;
  wire hit_tx  = paddr_i == sbg_pkg::ADDR_TX_CTL;
  wire hit_rx  = paddr_i == sbg_pkg::ADDR_RX_CTL;
  wire mapped  = hit_lo | hit_hi | hit_rc | hit_tx | hit_rx;
  wire div_wr  = wr_en && (hit_lo || hit_hi); // R5

  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;

  // rx idle is a pin level from the receiver clock domain: 3 flops, agree
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      rx_idle_s1_reg <= 1'b1;
      rx_idle_s2_reg <= 1'b1;
      rx_idle_s3_reg <= 1'b1;
      rx_idle_reg    <= 1'b1;
    end else begin
      rx_idle_s1_reg <= rx_idle_flag_i;
      rx_idle_s2_reg <= rx_idle_s1_reg;
      rx_idle_s3_reg <= rx_idle_s2_reg;
      if (rx_idle_s2_reg == rx_idle_s3_reg) rx_idle_reg <= rx_idle_s3_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      div_low_reg  <= sbg_pkg::RST_DIV;
      div_high_reg <= sbg_pkg::RST_DIV;
      rate_ctl_reg <= sbg_pkg::RST_CTL; // R1
      tx_ctl_reg   <= sbg_pkg::RST_CTL;
      rx_ctl_reg   <= sbg_pkg::RST_CTL;
    end else if (wr_en) begin
      if (hit_lo) div_low_reg  <= pwdata_i[7:0];
      if (hit_hi) div_high_reg <= pwdata_i[7:0];
      if (hit_rc) rate_ctl_reg <= pwdata_i[7:0] & sbg_pkg::RATE_CTL_MASK;
      if (hit_tx) tx_ctl_reg   <= pwdata_i[7:0] & sbg_pkg::TX_CTL_MASK;
      if (hit_rx) rx_ctl_reg   <= pwdata_i[7:0] & sbg_pkg::RX_CTL_MASK;
    end
  end

  wire [7:0] rate_ctl_rd = rate_ctl_reg | {1'b0, rx_idle_reg, 6'h00};
  wire [7:0] rd_byte = hit_lo ? div_low_reg  :
                       hit_hi ? div_high_reg :
                       hit_rc ? rate_ctl_rd  :
                       hit_tx ? tx_ctl_reg   :
                       hit_rx ? rx_ctl_reg   : 8'h00;

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) prdata_o <= 32'h00000000;
    else if (psel_i && !penable_i && !pwrite_i) prdata_o <= {24'h000000, rd_byte};
  end

  ////////////////////////////////////////////////////////////////////////
  assign cfg.sync_mode        = tx_ctl_reg[sbg_pkg::SYNC_BIT];
  assign cfg.wide_divider_sel = rate_ctl_reg[sbg_pkg::WIDE_DIV_BIT];
  assign cfg.high_speed_sel   = tx_ctl_reg[sbg_pkg::HIGH_SPD_BIT];
  assign cfg.divisor          = {div_high_reg, div_low_reg}; // R2

  // narrow mode uses only the low byte of the divisor
  wire [15:0] n_eff = cfg.wide_divider_sel ? cfg.divisor : {8'h00, cfg.divisor[7:0]}; // R1

  // multiplier per mode; one timer for both async and sync
  wire [5:0] pre_max = cfg.sync_mode ? sbg_pkg::PRE_4 :                   // R4 R7
                       (cfg.wide_divider_sel ?
                         (cfg.high_speed_sel ? sbg_pkg::PRE_4  : sbg_pkg::PRE_16) : // R3 R8
                         (cfg.high_speed_sel ? sbg_pkg::PRE_16 : sbg_pkg::PRE_64)); // R3 R8

  wire pre_done = pre_reg >= pre_max;
  wire cnt_done = cnt_reg >= n_eff;
  // a count left over from wide mode must not linger above 8 bits once narrow
  wire narrow_ovf = !cfg.wide_divider_sel && (cnt_reg[15:8] != 8'h00); // R1

  assign pre_next = (div_wr || pre_done) ? sbg_pkg::PRE_0 : pre_reg + 6'h01;
  assign cnt_next = div_wr ? sbg_pkg::CNT_0 :                            // R5
                    narrow_ovf ? sbg_pkg::CNT_0 :                        // R1
                    !pre_done ? cnt_reg :
                    cnt_done ? sbg_pkg::CNT_0 : cnt_reg + 16'h0001;

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      pre_reg  <= sbg_pkg::PRE_0;
      cnt_reg  <= sbg_pkg::CNT_0;
      tick_reg <= 1'b0;
    end else begin
      pre_reg  <= pre_next;
      cnt_reg  <= cnt_next;
      tick_reg <= !div_wr && pre_done && cnt_done;
    end
  end
  assign rate_tick_o = tick_reg;

  ////////////////////////////////////////////////////////////////////////
  a_div_clears: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // R5
    div_wr |=> (cnt_reg == 16'h0000 && pre_reg == 6'h00 && !rate_tick_o))
    else $error("divisor write did not clear timer");
  a_sync_rate: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // R4
    cfg.sync_mode |-> pre_max == 6'h03)
    else $error("sync prescale wrong");
  a_async_64: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // R3
    (!cfg.sync_mode && !cfg.wide_divider_sel && !cfg.high_speed_sel) |-> pre_max == 6'h3F)
    else $error("async narrow prescale wrong");
  a_async_16w: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // R3
    (!cfg.sync_mode && cfg.wide_divider_sel && !cfg.high_speed_sel) |-> pre_max == 6'h0F)
    else $error("async wide prescale wrong");
  a_async_hs: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // R8
    (!cfg.sync_mode && cfg.high_speed_sel) |->
      pre_max == (cfg.wide_divider_sel ? 6'h03 : 6'h0F))
    else $error("high speed prescale wrong");
  a_narrow_cnt: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // R1
    (!cfg.wide_divider_sel && $stable(cfg) && !div_wr && !$past(div_wr)) |->
      cnt_reg[15:8] == 8'h00 || $past(cfg.wide_divider_sel))
    else $error("narrow counter exceeded 8 bits");
  a_div_pair: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // R2
    (wr_en && hit_hi) |=> div_high_reg == $past(pwdata_i[7:0]))
    else $error("divisor high byte not stored");
  a_tick_pulse: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // R7
    rate_tick_o |=> !rate_tick_o)
    else $error("tick longer than one cycle");
  c_sync_tick: cover property (@(posedge core_clk_i) cfg.sync_mode && rate_tick_o);
  c_async_tick: cover property (@(posedge core_clk_i) !cfg.sync_mode && rate_tick_o);
  c_div_write: cover property (@(posedge core_clk_i) div_wr);
endmodule : sbg_top
`default_nettype wire

/* File: verification/sbg_rx_model.sv */
`timescale 1ns/1ps
`default_nettype none
// receiver side: reports idle and measures the gap between rate ticks
module sbg_rx_model (
  input  wire logic        clk_i,
  input  wire logic        tick_i,
  input  wire logic        busy_i,
  output logic             idle_o,
  output logic [15:0]      gap_o
);
  logic [15:0] cnt_reg;
  assign idle_o = ~busy_i;
  always_ff @(posedge clk_i) begin
    cnt_reg <= tick_i ? 16'h0001 : cnt_reg + 16'h0001;
    if (tick_i) gap_o <= cnt_reg;
  end
endmodule : sbg_rx_model
`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk = 1'b0, rst_b = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, busy = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, lfsr = 32'h52E1F9D5;
  logic        pready, pslverr, idle, tick, se;
  logic [15:0] gap;
  logic [7:0]  hi, lo;
  logic [2:0]  m;
  int          err_count = 0, n_checks = 0, cyc = 0, cnt;
  sbg_top dut (.core_clk_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .rx_idle_flag_i(idle), .rate_tick_o(tick));
  sbg_rx_model rx (.clk_i(clk), .tick_i(tick), .busy_i(busy), .idle_o(idle), .gap_o(gap));
  initial forever #2 clk = ~clk;
  // a hang anywhere ends here as a failure
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      give_verdict();
    end
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  // m = {sync, wide, high speed}; narrow mode ignores the high byte
  function automatic int per(input logic [2:0] k, input logic [7:0] h, input logic [7:0] l);
    int p;
    p = k[2] ? 4 : (k[1] ? (k[0] ? 4 : 16) : (k[0] ? 16 : 64));
    return p * ((k[1] ? int'(h) * 256 : 0) + int'(l) + 1);
  endfunction : per
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic wait_tick();
    cnt = 0;
    do begin
      @(posedge clk);
      cnt++;
    end while (tick !== 1'b1);
  endtask : wait_tick
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, sbg_pkg::ADDR_RATE_CTL, 32'h0);
    check(rd, 32'h00000040);
    apb(1'b1, 12'h020, 32'hFFFFFFFF);
    check({31'h0, se}, 32'h1);
    busy <= 1'b1;
    repeat (8) @(posedge clk);
    apb(1'b0, sbg_pkg::ADDR_RATE_CTL, 32'h0);
    check(rd, 32'h00000000);
    busy <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      lfsr = nxt(lfsr);
      m = 3'(i);
      hi = {7'h0, lfsr[8]};
      lo = (i == 7) ? 8'h00 : {5'h0, lfsr[2:0]};
      apb(1'b1, sbg_pkg::ADDR_TX_CTL, {27'h0, m[2], 1'b0, m[0], 2'b00});
      apb(1'b1, sbg_pkg::ADDR_RATE_CTL, {28'h0, m[1], 3'b000});
      apb(1'b1, sbg_pkg::ADDR_DIV_HIGH, {24'h0, hi});
      apb(1'b0, sbg_pkg::ADDR_DIV_HIGH, 32'h0);
      check(rd, {24'h0, hi});
      apb(1'b1, sbg_pkg::ADDR_DIV_LOW, {24'h0, lo});
      wait_tick();
      check({31'h0, cnt >= per(m, hi, lo) && cnt <= per(m, hi, lo) + 1}, 32'h1);
      wait_tick();
      @(posedge clk);
      check({16'h0, gap}, 32'(per(m, hi, lo)));
    end
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
